// ===== shac_pkg.sv
// shared constants for the storage health and converter control block
package shac_pkg;
  // register offsets (byte addresses on the register port)
  localparam logic [7:0] SHAC_OFS_RESULT    = 8'h05;
  localparam logic [7:0] SHAC_OFS_STATUS    = 8'h07;
  localparam logic [7:0] SHAC_OFS_CONV_CTL  = 8'h08;
  localparam logic [7:0] SHAC_OFS_READBACK  = 8'h09;
  localparam logic [7:0] SHAC_OFS_FORCE     = 8'h0a;
  localparam logic [7:0] SHAC_OFS_HCFG      = 8'h1f;
  localparam logic [7:0] SHAC_OFS_THR       = 8'h20;
  localparam logic [7:0] SHAC_OFS_SCALE     = 8'h27;

  // field positions
  localparam int SHAC_BIT_READY      = 7;  // status
  localparam int SHAC_BIT_FAULT      = 0;  // status
  localparam int SHAC_BIT_SWEEP      = 3;  // conv ctl, [2:0] = channel
  localparam int SHAC_BIT_SINGLE     = 4;
  localparam int SHAC_BIT_BUF_ON     = 5;
  localparam int SHAC_BIT_GO         = 6;
  localparam int SHAC_BIT_MAN_SINK   = 0;  // force reg
  localparam int SHAC_BIT_FORCE      = 1;
  localparam int SHAC_BIT_HC_DISABLE = 5;  // hcfg, [3:0] = discharge time
  localparam int SHAC_BIT_DOUBLE     = 0;  // scale
  localparam int SHAC_BIT_QUAD       = 1;

  // values after reset
  localparam logic [3:0] SHAC_RST_TSET = 4'h4;
  localparam logic [3:0] SHAC_RST_THR  = 4'h0;

  // channel codes
  localparam logic [2:0] SHAC_CH_IIN  = 3'h0;
  localparam logic [2:0] SHAC_CH_VIN  = 3'h1;
  localparam logic [2:0] SHAC_CH_VSTR = 3'h2;
  localparam logic [2:0] SHAC_CH_VOUT = 3'h3;
  localparam logic [2:0] SHAC_CH_TEMP = 3'h4;
  localparam logic [2:0] SHAC_CH_GND  = 3'h5;
  localparam int         SHAC_NUM_CH  = 6;

  // timing
  localparam int SHAC_CLK_HZ       = 25_000_000;
  localparam int SHAC_MS_CYCLES    = SHAC_CLK_HZ / 1000;
  localparam int SHAC_SINK2_US     = 200;
  localparam int SHAC_SINK2_CYCLES = SHAC_CLK_HZ / 1_000_000 * SHAC_SINK2_US;
  localparam int SHAC_PERIOD_MIN   = 4;
  localparam int SHAC_PERIOD_MS    = SHAC_PERIOD_MIN * 60_000;
  localparam int SHAC_TSET_BASE_MS = 2;    // upper bit clear: 2 << code
  localparam int SHAC_TSET_STEP_MS = 128;  // upper bit set: 128 * (3 + code)
  localparam int SHAC_TSET_OFS     = 3;
endpackage : shac_pkg

// ===== shac_ctrl.sv
// health monitor sequencer and monitoring converter sequencer
// Notes on behaviour
// RULE1 - storage power-good true only while storage node above selected threshold
// RULE2 - one 4-bit threshold field serves power-good and health check
// RULE3 - check: 10mA sink for programmed time, then 50mA sink 200us
// RULE4 - drop beyond threshold during check sets fault and pulls interrupt low
// RULE5 - boost re-enabled once the discharge interval ends
// RULE6 - disable bit suppresses automatic health checks
// RULE7 - force bit launches exactly one check, even when disabled
// RULE8 - automatic check every 4 minutes, scaled to 8 or 16
// RULE9 - manual sink bit holds 10mA sink on; threshold still applies
// RULE10 - discharge field: 2ms doubling to 256ms, or 384 to 1280ms
// RULE11 - 8-bit results, one register per channel, six-to-one selector
// RULE12 - 3-bit channel codes for six channels
// RULE13 - host sets single, clears sweep, sets buffer for single-shot
// RULE14 - host sets conversion and readback channels equal in single-shot
// RULE15 - go in single-shot converts once, sets ready, interrupt, clears go
// RULE16 - selected result presented at offset 0x05
// RULE17 - single-shot ready and interrupt stay until result is read
// RULE18 - host clears single, sets sweep and buffer, then go for polling
// RULE19 - polling sweeps all channels, overwrites results, sets ready per sweep
// RULE20 - polling completion never drives the interrupt
// RULE21 - host checks ready in polling; conversion field selects shown result
// RULE22 - interrupt low while any source pending
`timescale 1ns/100ps
module shac_ctrl
  import shac_pkg::*;
#(
  parameter int TICK_CYCLES  = SHAC_MS_CYCLES,
  parameter int SINK2_CYCLES = SHAC_SINK2_CYCLES,
  parameter int PERIOD_MS    = SHAC_PERIOD_MS
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       storage_above_thr,
  input  wire logic       storage_drop_exceeded,
  output logic      [3:0] health_drop_threshold,
  output logic            storage_power_good,
  output logic            sink_10ma_on,
  output logic            sink_50ma_on,
  output logic            boost_enable,
  output logic            converter_buffer_on,
  output logic            conv_start,
  output logic      [2:0] conv_channel,
  input  wire logic       conv_done,
  input  wire logic [7:0] conv_data,
  output logic            interrupt_low_out
);

  // the longest period limit is four times PERIOD_MS and must fit 22 bits
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || SINK2_CYCLES < 1 ||
      SINK2_CYCLES > 65535 || PERIOD_MS < 1 || PERIOD_MS > 1_048_575)
  begin : g_bad_timing
    $error("shac_ctrl: timing parameter out of range");
  end

  typedef enum logic [1:0] {SHAC_H_IDLE, SHAC_H_SINK1, SHAC_H_SINK2}
    shac_health_e;
  typedef enum logic [1:0] {SHAC_C_IDLE, SHAC_C_START, SHAC_C_WAIT}
    shac_conv_e;

  // discharge length in ms for a 4-bit code
  function automatic logic [10:0] shac_tset_ms(input logic [3:0] code);
    if (code[3])
      shac_tset_ms =
        11'(SHAC_TSET_STEP_MS * (SHAC_TSET_OFS + code[2:0])); // RULE10
    else
      shac_tset_ms = 11'(SHAC_TSET_BASE_MS << code[2:0]); // RULE10
  endfunction : shac_tset_ms

  function automatic logic shac_hit(input logic [7:0] ofs);
    shac_hit = (reg_addr == ofs);
  endfunction : shac_hit

  // register storage
  logic [2:0]   conv_sel_r;
  logic [2:0]   read_sel_r;
  logic         sweep_r, single_r, buf_r, go_r;
  logic         man_sink_r, force_r;
  logic [3:0]   tset_r, thr_r;
  logic         hc_dis_r;
  logic [1:0]   scale_r;
  logic         ready_r, fault_r, conv_irq_r;
  logic [7:0]   result_r [SHAC_NUM_CH];

  shac_health_e hstate_r;
  shac_conv_e   cstate_r;
  logic [15:0]  tick_cnt_r;
  logic         tick;
  logic [10:0]  dis_ms_r;
  logic [15:0]  sink2_cnt_r;
  logic [21:0]  period_ms_r;
  logic [21:0]  period_lim;
  logic [2:0]   cur_ch_r;
  logic         wr_conv, wr_force, rd_result, rd_status, auto_due, launch;

  assign wr_conv   = ce && reg_wr && shac_hit(SHAC_OFS_CONV_CTL);
  assign wr_force  = ce && reg_wr && shac_hit(SHAC_OFS_FORCE);
  assign rd_result = ce && reg_rd && shac_hit(SHAC_OFS_RESULT);
  assign rd_status = ce && reg_rd && shac_hit(SHAC_OFS_STATUS);

  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_sel_r <= SHAC_CH_IIN;
      tset_r     <= SHAC_RST_TSET;
      thr_r      <= SHAC_RST_THR;
      hc_dis_r   <= 1'b0;
      scale_r    <= 2'h0;
      man_sink_r <= 1'b0;
    end else if (ce && reg_wr) begin
      if (shac_hit(SHAC_OFS_READBACK))
        read_sel_r <= reg_wdata[2:0];
      if (shac_hit(SHAC_OFS_HCFG)) begin
        tset_r   <= reg_wdata[3:0];
        hc_dis_r <= reg_wdata[SHAC_BIT_HC_DISABLE];
      end
      if (shac_hit(SHAC_OFS_THR))
        thr_r <= reg_wdata[3:0];
      if (shac_hit(SHAC_OFS_SCALE))
        scale_r <= reg_wdata[1:0];
      if (shac_hit(SHAC_OFS_FORCE))
        man_sink_r <= reg_wdata[SHAC_BIT_MAN_SINK];
    end
  end

  // converter control; go is cleared by hardware after a single shot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_sel_r <= SHAC_CH_IIN;
      sweep_r    <= 1'b0;
      single_r   <= 1'b0;
      buf_r      <= 1'b0;
      go_r       <= 1'b0;
    end else if (ce) begin
      if (wr_conv) begin
        conv_sel_r <= reg_wdata[2:0];
        sweep_r    <= reg_wdata[SHAC_BIT_SWEEP];
        single_r   <= reg_wdata[SHAC_BIT_SINGLE];
        buf_r      <= reg_wdata[SHAC_BIT_BUF_ON];
        go_r       <= reg_wdata[SHAC_BIT_GO];
      end else if (cstate_r == SHAC_C_WAIT && conv_done && single_r) begin
        go_r <= 1'b0; // RULE15
      end
    end
  end

  // one-cycle force request, consumed by the health sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      force_r <= 1'b0;
    else if (ce)
      force_r <= wr_force && reg_wdata[SHAC_BIT_FORCE];
  end

  // millisecond tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      tick_cnt_r <= 16'h0000;
    else if (ce)
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  // automatic period; quad wins when both scaling bits are set
  always_comb begin
    if (scale_r[SHAC_BIT_QUAD])
      period_lim = 22'(PERIOD_MS * 4); // RULE8
    else if (scale_r[SHAC_BIT_DOUBLE])
      period_lim = 22'(PERIOD_MS * 2); // RULE8
    else
      period_lim = 22'(PERIOD_MS); // RULE8
  end

  // the period timer is cleared while disabled or while a check runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      period_ms_r <= 22'h000000;
    else if (ce) begin
      if (hc_dis_r || hstate_r != SHAC_H_IDLE || auto_due)
        period_ms_r <= 22'h000000; // RULE6
      else if (tick)
        period_ms_r <= period_ms_r + 22'h000001;
    end
  end
  assign auto_due = !hc_dis_r && period_ms_r >= period_lim; // RULE6 RULE8
  assign launch   = force_r || auto_due; // RULE7

  // health check sequencer; a force while a check runs is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hstate_r    <= SHAC_H_IDLE;
      dis_ms_r    <= 11'h000;
      sink2_cnt_r <= 16'h0000;
    end else if (ce) begin
      unique case (hstate_r)
        SHAC_H_IDLE: begin
          dis_ms_r <= 11'h000;
          if (launch)
            hstate_r <= SHAC_H_SINK1; // RULE3
        end
        SHAC_H_SINK1: begin
          if (tick)
            dis_ms_r <= dis_ms_r + 11'h001;
          if (tick && dis_ms_r + 11'h001 >= shac_tset_ms(tset_r)) begin
            hstate_r    <= SHAC_H_SINK2; // RULE3
            sink2_cnt_r <= 16'h0000;
          end
        end
        SHAC_H_SINK2: begin
          sink2_cnt_r <= sink2_cnt_r + 16'h0001;
          if (sink2_cnt_r == 16'(SINK2_CYCLES - 1))
            hstate_r <= SHAC_H_IDLE; // RULE3 RULE5
        end
      endcase
    end
  end

  assign sink_10ma_on = (hstate_r == SHAC_H_SINK1) || man_sink_r; // RULE3 RULE9
  assign sink_50ma_on = (hstate_r == SHAC_H_SINK2); // RULE3
  // boost stays off for the whole discharge so the drop is not masked
  assign boost_enable = (hstate_r == SHAC_H_IDLE); // RULE5
  assign health_drop_threshold = thr_r; // RULE2 RULE9
  assign storage_power_good = storage_above_thr; // RULE1

  // fault flag: a new fault beats the read that would clear it
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      fault_r <= 1'b0;
    else if (ce) begin
      if ((hstate_r != SHAC_H_IDLE || man_sink_r) && storage_drop_exceeded)
        fault_r <= 1'b1; // RULE4 RULE9
      else if (rd_status)
        fault_r <= 1'b0;
    end
  end

  // converter sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cstate_r <= SHAC_C_IDLE;
      cur_ch_r <= SHAC_CH_IIN;
    end else if (ce) begin
      unique case (cstate_r)
        SHAC_C_IDLE: begin
          if (go_r && buf_r && !wr_conv) begin
            cur_ch_r <= single_r ? conv_sel_r : SHAC_CH_IIN; // RULE12
            cstate_r <= SHAC_C_START;
          end
        end
        SHAC_C_START:
          cstate_r <= SHAC_C_WAIT;
        SHAC_C_WAIT: begin
          if (conv_done) begin
            if (single_r || !go_r || !sweep_r)
              cstate_r <= SHAC_C_IDLE; // RULE15
            else begin
              cstate_r <= SHAC_C_START; // RULE19
              cur_ch_r <= (cur_ch_r == SHAC_CH_GND) ? SHAC_CH_IIN
                                                    : cur_ch_r + 3'h1;
            end
          end
        end
      endcase
    end
  end
  assign conv_start          = ce && (cstate_r == SHAC_C_START);
  assign conv_channel        = cur_ch_r;
  assign converter_buffer_on = buf_r;

  // per-channel result registers
  genvar gi;
  generate
    for (gi = 0; gi < SHAC_NUM_CH; gi++) begin : g_res
      always_ff @(posedge clk or posedge reset) begin
        if (reset)
          result_r[gi] <= 8'h00;
        else if (ce && cstate_r == SHAC_C_WAIT && conv_done &&
                 cur_ch_r == 3'(gi))
          result_r[gi] <= conv_data; // RULE11 RULE19
      end
    end
  endgenerate

  // ready and completion interrupt; completion beats a clearing read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_r    <= 1'b0;
      conv_irq_r <= 1'b0;
    end else if (ce) begin
      if (cstate_r == SHAC_C_WAIT && conv_done && single_r) begin
        ready_r    <= 1'b1; // RULE15
        conv_irq_r <= 1'b1; // RULE15 RULE20
      end else if (cstate_r == SHAC_C_WAIT && conv_done &&
                   cur_ch_r == SHAC_CH_GND) begin
        ready_r <= 1'b1; // RULE19 RULE20
      end else if (rd_result && single_r) begin
        ready_r    <= 1'b0; // RULE17
        conv_irq_r <= 1'b0; // RULE17
      end else if (wr_conv && reg_wdata[SHAC_BIT_GO]) begin
        ready_r    <= 1'b0;
        conv_irq_r <= 1'b0;
      end
    end
  end

  assign interrupt_low_out = !(fault_r || conv_irq_r); // RULE4 RULE22

  // read data; result shows readback field in single-shot, else conv field
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd) begin
      unique case (reg_addr)
        SHAC_OFS_RESULT: begin
          if (single_r)
            reg_rdata <= (read_sel_r <= SHAC_CH_GND) ?
                         result_r[read_sel_r] : 8'h00; // RULE16 RULE11
          else
            reg_rdata <= (conv_sel_r <= SHAC_CH_GND) ?
                         result_r[conv_sel_r] : 8'h00; // RULE21
        end
        SHAC_OFS_STATUS:
          reg_rdata <= {ready_r, 6'h00, fault_r};
        SHAC_OFS_CONV_CTL:
          reg_rdata <= {1'b0, go_r, buf_r, single_r, sweep_r, conv_sel_r};
        SHAC_OFS_READBACK:
          reg_rdata <= {5'h00, read_sel_r};
        SHAC_OFS_FORCE:
          reg_rdata <= {7'h00, man_sink_r};
        SHAC_OFS_HCFG:
          reg_rdata <= {2'h0, hc_dis_r, 1'b0, tset_r};
        SHAC_OFS_THR:
          reg_rdata <= {4'h0, thr_r};
        SHAC_OFS_SCALE:
          reg_rdata <= {6'h00, scale_r};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : shac_ctrl

// ===== shac_ctrl_monitor.sv
// port checker for the health and converter sequencer
`timescale 1ns/100ps
module shac_ctrl_monitor
  import shac_pkg::*;
#(
  parameter int SINK2_CYCLES = SHAC_SINK2_CYCLES
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       storage_above_thr,
  input wire logic       storage_drop_exceeded,
  input wire logic       storage_power_good,
  input wire logic       sink_10ma_on,
  input wire logic       sink_50ma_on,
  input wire logic       boost_enable,
  input wire logic       converter_buffer_on,
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic       interrupt_low_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  int n50_r;

  // counts only enabled cycles, so a frozen ce cannot stretch the figure
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      n50_r <= 0;
    end else if (!sink_50ma_on) begin
      n50_r <= 0;
    end else if (ce) begin
      n50_r <= n50_r + 1;
    end
  end

  a_pg_follow: assert property (storage_power_good == storage_above_thr)
    else $error("power good differs from comparator");
  a_sink2_len: assert property ($fell(sink_50ma_on) |-> n50_r == SINK2_CYCLES)
    else $error("second sink phase has wrong length");
  a_boost_back: assert property ($fell(sink_50ma_on) |-> boost_enable)
    else $error("boost not back after discharge");
  a_force_starts: assert property (ce && reg_wr && reg_addr == SHAC_OFS_FORCE
    && reg_wdata[SHAC_BIT_FORCE] && boost_enable && !sink_50ma_on
    |-> ##2 (sink_10ma_on && !boost_enable))
    else $error("forced check did not start");
  a_start_buf: assert property (conv_start |-> converter_buffer_on)
    else $error("conversion started with buffer off");
  a_fault_irq: assert property (ce && storage_drop_exceeded
    && (sink_10ma_on || sink_50ma_on) |=> !interrupt_low_out)
    else $error("drop during discharge gave no interrupt");
  a_irq_cause: assert property ($fell(interrupt_low_out) |->
    $past(conv_done) || $past(storage_drop_exceeded))
    else $error("interrupt without a source");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  c_check: cover property ($fell(sink_50ma_on));
  c_conv: cover property (conv_start);
  c_irq: cover property ($fell(interrupt_low_out));
endmodule : shac_ctrl_monitor

bind shac_ctrl shac_ctrl_monitor #(.SINK2_CYCLES(SINK2_CYCLES)) mon_u (
  .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .storage_above_thr(storage_above_thr),
  .storage_drop_exceeded(storage_drop_exceeded),
  .storage_power_good(storage_power_good), .sink_10ma_on(sink_10ma_on),
  .sink_50ma_on(sink_50ma_on), .boost_enable(boost_enable),
  .converter_buffer_on(converter_buffer_on), .conv_start(conv_start),
  .conv_done(conv_done), .interrupt_low_out(interrupt_low_out));

// ===== shac_conv_model.sv
// converter stand-in: answers each start after lat + 1 cycles
`timescale 1ns/100ps
module shac_conv_model (
  input  wire logic       clk,
  input  wire logic       conv_start,
  input  wire logic [2:0] conv_channel,
  input  wire logic [3:0] lat,
  output logic            conv_done,
  output logic      [7:0] conv_data
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] ch_r = 3'h0;
  logic       busy_r = 1'b0;

  initial conv_data = 8'h00;
  always @(posedge clk) begin
    conv_done <= 1'b0;
    // data only valid with done; toggles otherwise so stale use shows
    conv_data <= ~conv_data;
    if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
      ch_r <= conv_channel;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= {5'h15, ch_r};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : shac_conv_model

// ===== tb_storage_health_and_adc_control.sv
// self-checking bench for the health and converter sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_storage_health_and_adc_control
  import shac_pkg::*;
;
  localparam int TK = 4, S2 = 3, PM = 5;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic above = 1'b0, drop = 1'b0, poll = 1'b0;
  logic pg, s10, s50, boost, buf_on, cst, cdone, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cdata, v;
  logic [3:0] thr, lat = 4'h1;
  logic [2:0] cch;
  int fail_count = 0, n_compared = 0, n_start = 0, poll_irq = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (cst === 1'b1) n_start++;
  always @(negedge clk) if (poll && irq !== 1'b1) poll_irq++;

  shac_ctrl #(.TICK_CYCLES(TK), .SINK2_CYCLES(S2), .PERIOD_MS(PM)) dut_u (
    .clk(clk), .reset(reset), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .storage_above_thr(above), .storage_drop_exceeded(drop),
    .health_drop_threshold(thr), .storage_power_good(pg),
    .sink_10ma_on(s10), .sink_50ma_on(s50), .boost_enable(boost),
    .converter_buffer_on(buf_on), .conv_start(cst), .conv_channel(cch),
    .conv_done(cdone), .conv_data(cdata), .interrupt_low_out(irq));
  shac_conv_model cm_u (.clk(clk), .conv_start(cst), .conv_channel(cch),
    .lat(lat), .conv_done(cdone), .conv_data(cdata));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, v)
  endtask : rdc

  task automatic t_regs();
    rdc("hcfg_rst", SHAC_OFS_HCFG, 8'h04);
    rdc("unmapped", 8'h30, 8'h00);
    wr(SHAC_OFS_THR, 8'hfb);
    rdc("thr", SHAC_OFS_THR, 8'h0b);
    `CHK("thr_out", 4'hb, thr)
    above = 1'b1;
    #1;
    `CHK("pg", 1'b1, pg)
    $display("t_regs finished");
  endtask : t_regs

  task automatic t_force();
    logic [3:0] codes [4];
    int ms, n10, n50, i;
    codes = '{4'h0, 4'h7, 4'h8, 4'hf};
    for (int k = 0; k < 4; k++) begin
      wr(SHAC_OFS_HCFG, {4'h2, codes[k]});
      for (i = 0; i < 9999 && !boost; i++) @(negedge clk);
      ms = codes[k][3] ? 128 * (3 + codes[k][2:0]) : 2 << codes[k][2:0];
      wr(SHAC_OFS_FORCE, 8'h02);
      for (i = 0; i < 9 && !s10; i++) @(negedge clk);
      for (n10 = 0; n10 < 6000 && s10; n10++) begin
        drop = (k == 0 && n10 == 2);
        @(negedge clk);
      end
      for (n50 = 0; n50 < 99 && s50; n50++) @(negedge clk);
      `CHK("t10", 1'b1, n10 > (ms - 1) * TK && n10 <= ms * TK)
      `CHK("t50", S2, n50)
      `CHK("boost", 1'b1, boost)
      if (k == 0) begin
        `CHK("irq_flt", 1'b0, irq)
        rdc("fault", SHAC_OFS_STATUS, 8'h01);
      end
    end
    repeat (40) @(negedge clk);
    `CHK("one_check", 1'b0, s10)
    wr(SHAC_OFS_FORCE, 8'h01);
    repeat (30) @(negedge clk);
    drop = 1'b1;
    @(negedge clk);
    drop = 1'b0;
    `CHK("man_irq", 1'b0, irq)
    wr(SHAC_OFS_FORCE, 8'h00);
    `CHK("man_off", 1'b0, s10)
    rdc("man_flt", SHAC_OFS_STATUS, 8'h01);
    $display("t_force finished");
  endtask : t_force

  task automatic t_conv();
    int i, k;
    for (int c = 0; c < 6; c++) begin
      lat = c[0] ? 4'h9 : 4'h1;
      wr(SHAC_OFS_READBACK, 8'(c));
      wr(SHAC_OFS_CONV_CTL, 8'h70 | 8'(c));
      for (i = 0; i < 40 && irq; i++) @(negedge clk);
      rdc("ready", SHAC_OFS_STATUS, 8'h80);
      rdc("go_clr", SHAC_OFS_CONV_CTL, 8'h30 | 8'(c));
      `CHK("irq_hold", 1'b0, irq)
      `CHK("buf_on", 1'b1, buf_on)
      rdc("result", SHAC_OFS_RESULT, {5'h15, 3'(c)});
      `CHK("irq_rel", 1'b1, irq)
    end
    k = n_start;
    wr(SHAC_OFS_CONV_CTL, 8'h50);
    repeat (20) @(negedge clk);
    `CHK("no_buf", k, n_start)
    poll = 1'b1;
    wr(SHAC_OFS_CONV_CTL, 8'h68);
    v = 8'h00;
    for (i = 0; i < 50 && !v[7]; i++) rd(SHAC_OFS_STATUS);
    `CHK("sweep", 1'b1, v[7] && n_start - k >= 6)
    for (int c = 0; c < 6; c++) begin
      wr(SHAC_OFS_CONV_CTL, 8'h68 | 8'(c));
      rdc("poll_res", SHAC_OFS_RESULT, {5'h15, 3'(c)});
    end
    `CHK("resweep", 1'b1, n_start - k >= 8)
    wr(SHAC_OFS_CONV_CTL, 8'h00);
    poll = 1'b0;
    `CHK("poll_irq", 0, poll_irq)
    $display("t_conv finished");
  endtask : t_conv

  task automatic t_period();
    int mult [4];
    int n, i, seen;
    logic ok;
    mult = '{1, 2, 4, 4};
    for (int s = 0; s < 4; s++) begin
      wr(SHAC_OFS_SCALE, 8'(s));
      wr(SHAC_OFS_HCFG, 8'h00);
      for (i = 0; i < 999 && !s10; i++) @(negedge clk);
      for (i = 0; i < 999 && !boost; i++) @(negedge clk);
      for (n = 0; n < 999 && !s10; n++) @(negedge clk);
      ok = n >= (PM * mult[s] - 1) * TK && n <= PM * mult[s] * TK + 3;
      `CHK("period", 1'b1, ok)
    end
    wr(SHAC_OFS_HCFG, 8'h20);
    for (i = 0; i < 999 && !boost; i++) @(negedge clk);
    seen = 0;
    repeat (400) begin
      @(negedge clk);
      seen = seen | s10;
    end
    `CHK("disabled", 0, seen)
    $display("t_period finished");
  endtask : t_period

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_force();
    t_conv();
    t_period();
    end_of_test();
  end

  // the whole sequence needs about 9k cycles; the 100k-cycle limit allows about eleven times that
  initial begin
    #4_000_000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_storage_health_and_adc_control
